// [rtl/ports_params.svh]
/*
 * Register selects, field positions, mode codes and reset values for the
 * parallel port block. Assumes inclusion by bare name from rtl/ files.
 */
`ifndef PORTS_PARAMS_SVH
`define PORTS_PARAMS_SVH

// Register selects on the four select lines
`define REG_PORT_B_DATA 4'h0
`define REG_PORT_A_DATA 4'h1
`define REG_PORT_B_DIR 4'h2
`define REG_PORT_A_DIR 4'h3
`define REG_AUX_CTRL 4'hb
`define REG_PERIPH_CTRL 4'hc
`define REG_FLAGS 4'hd
`define REG_PORT_A_QUIET 4'hf

// Auxiliary control: input latch enables
`define AUX_LATCH_A_BIT 0
`define AUX_LATCH_B_BIT 1

// Peripheral control fields
`define PCR_A_IN_EDGE_BIT 0
`define PCR_A_IO_LSB 1
`define PCR_A_IO_MSB 3
`define PCR_B_IN_EDGE_BIT 4
`define PCR_B_IO_LSB 5
`define PCR_B_IO_MSB 7

// Control-io field codes (output modes have the top bit set)
`define IO_HANDSHAKE 3'h4
`define IO_PULSE 3'h5
`define IO_LOW 3'h6
`define IO_HIGH 3'h7

// Flag register bit positions
`define FLAG_A_IO_BIT 0
`define FLAG_A_IN_BIT 1
`define FLAG_B_IO_BIT 3
`define FLAG_B_IN_BIT 4

// Reset value, port width and capture buffer depth
`define RESET_BYTE 8'h00
`define PORT_WIDTH 8
`define FIFO_DEPTH 8

`endif

// [rtl/ports_pkg.sv]
/*
 * Types shared by the parallel port block.
 * Assumes ports_params.svh is compiled alongside.
 */
package ports_pkg;

    // Behaviour of a control-io line
    typedef enum logic [2:0] {
        IoInput,
        IoHandshake,
        IoPulse,
        IoLow,
        IoHigh
    } io_mode_t;

    // Whole state of the port block
    typedef struct packed {
        logic [7:0] outA;      // Output register A
        logic [7:0] outB;      // Output register B
        logic [7:0] dirA;      // Direction A, 1 = output
        logic [7:0] dirB;      // Direction B, 1 = output
        logic [7:0] aux;       // Latch enables
        logic [7:0] pctl;      // Control-line modes
        logic [7:0] flags;     // Sticky edge flags
        logic [7:0] latchB;    // Port B capture
        logic ioAOut;          // Port A control-io level
        logic ioBOut;          // Port B control-io level
        logic [7:0] rdData;    // Read data to bus
        logic rdValid;         // Bus driven
    } port_state_t;

endpackage

// [rtl/sync_edge.sv]
/*
 * Two-flop synchroniser with a selectable-polarity edge detector.
 * Assumes an asynchronous pin and a clean synchronous-release reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sync_edge (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Pin and polarity
    input wire logic pinIn,
    input wire logic risingSel,
    // One-cycle edge pulse
    output logic edgePulse
);

    // Sync chain plus previous settled value
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } sync_state_t;

    sync_state_t q, d;

    // Only s2 and prev feed the detector; s1 stays isolated
    always_comb begin
        d.s1 = pinIn;
        d.s2 = q.s1;
        d.prev = q.s2;
    end

    // Edge of the settled level, one pulse per transition of the selected polarity
    assign edgePulse = risingSel ? (q.s2 & ~q.prev) : (~q.s2 & q.prev);

    // State register
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// [rtl/fifo_buffer.sv]
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and a synchronous-release reset.
 */
`timescale 1ns/1ps
`default_nettype none

module fifo_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int AW = $clog2(DEPTH);

    // Storage and pointers
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t q, d;
    logic push, pop;

    // Honest flags from the occupancy count
    assign inReady = (q.count != DEPTH[AW:0]);
    assign outValid = (q.count != '0);
    assign outData = q.mem[q.rdPtr];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // Next state
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wrPtr] = inData;
            d.wrPtr = q.wrPtr + 1'b1;
        end
        if (pop) begin
            d.rdPtr = q.rdPtr + 1'b1;
        end
        // Simultaneous push and pop keep the count
        if (push && !pop) begin
            d.count = q.count + 1'b1;
        end else if (pop && !push) begin
            d.count = q.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// [rtl/parallel_ports.sv]
/*
 * Two 8-bit peripheral ports with direction, output and input registers,
 * input latching on control-line edges and read/write handshaking.
 * Assumes a host that drives selects, read/write and data synchronous to
 * sys_clk, one register access per selected clock cycle.
 */
`include "ports_params.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: Direction bit zero input, one output
// R2: Output pins follow output register bits
// R3: Writes to input pins stored, not driven
// R4: Port read returns input register contents
// R5: Unlatched port A follows live pins
// R6: Latched port A holds edge-captured pins
// R7: Reading latched A returns to transparent
// R8: Port A reads actual pin levels
// R9: Port B output pins read register
// R10: Port B inputs read latched or live
// R11: Latch enables live in auxiliary control
// R12: A handshakes both ways, B writes only
// R13: Read handshake: A input ready, io taken
// R14: Data-ready edge sets pollable flag
// R15: Peripheral signals data ready when valid
// R16: Peripheral presents next byte after taken
// R17: Reset clears registers, all pins input
// R18: Select fifteen is port A without handshake
// R19: Data-taken pulse or level, released by ready
// R20: Control inputs synchronised before edge detect
module parallel_ports (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Host register port
    input wire logic chipSel,
    input wire logic chipSelN,
    input wire logic [3:0] regSel,
    input wire logic readNotWrite,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    // Port A pins
    input wire logic [7:0] port_a_pins_in,
    output logic [7:0] port_a_pins_out,
    output logic [7:0] port_a_pins_oe,
    // Port B pins
    input wire logic [7:0] port_b_pins_in,
    output logic [7:0] port_b_pins_out,
    output logic [7:0] port_b_pins_oe,
    // Port A control lines
    input wire logic port_a_ctrl_in,
    input wire logic port_a_ctrl_io_in,
    output logic port_a_ctrl_io_out,
    output logic port_a_ctrl_io_oe,
    // Port B control lines
    input wire logic port_b_ctrl_in,
    input wire logic port_b_ctrl_io_in,
    output logic port_b_ctrl_io_out,
    output logic port_b_ctrl_io_oe,
    // Capture buffer has room
    output logic captureReady
);

    // Control-io field to mode
    function automatic ports_pkg::io_mode_t decodeIo(input logic [2:0] field);
        ports_pkg::io_mode_t m;
        case (field)
            `IO_HANDSHAKE: m = ports_pkg::IoHandshake;
            `IO_PULSE: m = ports_pkg::IoPulse;
            `IO_LOW: m = ports_pkg::IoLow;
            `IO_HIGH: m = ports_pkg::IoHigh;
            default: m = ports_pkg::IoInput;
        endcase
        return m;
    endfunction

    // Level driven on a control-io line in output modes
    function automatic logic ioLevel(input ports_pkg::io_mode_t m, input logic held);
        logic v;
        case (m)
            ports_pkg::IoLow: v = 1'b0;
            ports_pkg::IoHigh: v = 1'b1;
            default: v = held;
        endcase
        return v;
    endfunction

    // Reset release chain
    logic rstMeta, rstSyncN;

    // Reset asserts at once, releases after two edges
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    ports_pkg::port_state_t q, d;   // Block state
    ports_pkg::io_mode_t modeA;     // Port A control-io mode
    ports_pkg::io_mode_t modeB;     // Port B control-io mode
    logic edgeAIn, edgeAIo;         // Port A control edges
    logic edgeBIn, edgeBIo;         // Port B control edges
    logic fifoValid, fifoPop;       // Capture drain side
    logic [7:0] fifoHead;           // Oldest captured byte
    logic capPush;                  // Capture request
    logic latchA, latchB;           // Latch enables
    logic sel, rd, wr;              // Bus decode
    logic accA, accAQuiet;          // Port A data accesses
    logic [7:0] inRegA, inRegB;     // Input register views

    assign modeA = decodeIo(q.pctl[`PCR_A_IO_MSB:`PCR_A_IO_LSB]);
    assign modeB = decodeIo(q.pctl[`PCR_B_IO_MSB:`PCR_B_IO_LSB]);
    assign latchA = q.aux[`AUX_LATCH_A_BIT]; // R11
    assign latchB = q.aux[`AUX_LATCH_B_BIT]; // R11

    // Control inputs are synchronised before any edge is taken
    sync_edge u_sync_a_in ( // R20
        .clk(sys_clk),
        .rstN(rstSyncN),
        .pinIn(port_a_ctrl_in),
        .risingSel(q.pctl[`PCR_A_IN_EDGE_BIT]),
        .edgePulse(edgeAIn)
    );
    sync_edge u_sync_a_io ( // R20
        .clk(sys_clk),
        .rstN(rstSyncN),
        .pinIn(port_a_ctrl_io_in),
        .risingSel(q.pctl[`PCR_A_IO_LSB+1]),
        .edgePulse(edgeAIo)
    );
    sync_edge u_sync_b_in ( // R20
        .clk(sys_clk),
        .rstN(rstSyncN),
        .pinIn(port_b_ctrl_in),
        .risingSel(q.pctl[`PCR_B_IN_EDGE_BIT]),
        .edgePulse(edgeBIn)
    );
    sync_edge u_sync_b_io ( // R20
        .clk(sys_clk),
        .rstN(rstSyncN),
        .pinIn(port_b_ctrl_io_in),
        .risingSel(q.pctl[`PCR_B_IO_LSB+1]),
        .edgePulse(edgeBIo)
    );

    // Bus decode: one access per selected cycle
    assign sel = chipSel & ~chipSelN;
    assign rd = sel & readNotWrite;
    assign wr = sel & ~readNotWrite;
    assign accA = sel & (regSel == `REG_PORT_A_DATA);
    assign accAQuiet = sel & (regSel == `REG_PORT_A_QUIET); // R18

    // Edge captures queue so a fast peripheral is not lost
    assign capPush = latchA & edgeAIn; // R6
    assign fifoPop = latchA & rd & (accA | accAQuiet); // R7

    fifo_buffer #(
        .WIDTH(`PORT_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) u_capture (
        .clk(sys_clk),
        .rstN(rstSyncN),
        .inValid(capPush),
        .inReady(captureReady),
        .inData(port_a_pins_in),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoHead)
    );

    // Port A sees the held capture, else the live pin levels
    always_comb begin
        if (latchA && fifoValid) begin
            inRegA = fifoHead; // R6
        end else begin
            inRegA = port_a_pins_in; // R5 R8
        end
    end

    // Port B: outputs read back the register, inputs live or latched
    always_comb begin
        for (int i = 0; i < `PORT_WIDTH; i++) begin
            if (q.dirB[i]) begin
                inRegB[i] = q.outB[i]; // R9
            end else if (latchB) begin
                inRegB[i] = q.latchB[i]; // R10
            end else begin
                inRegB[i] = port_b_pins_in[i]; // R10
            end
        end
    end

    // Next-state logic
    always_comb begin
        d = q;
        d.rdValid = rd;
        d.rdData = `RESET_BYTE;

        // Register writes; input-pin bits are stored all the same
        if (wr) begin
            case (regSel)
                `REG_PORT_B_DATA: d.outB = dataIn; // R3
                `REG_PORT_A_DATA, `REG_PORT_A_QUIET: d.outA = dataIn; // R3
                `REG_PORT_B_DIR: d.dirB = dataIn; // R1
                `REG_PORT_A_DIR: d.dirA = dataIn; // R1
                `REG_AUX_CTRL: d.aux = dataIn; // R11
                `REG_PERIPH_CTRL: d.pctl = dataIn;
                `REG_FLAGS: d.flags = q.flags & ~dataIn;
                default: d.outA = q.outA;
            endcase
        end

        // Register reads, registered onto the bus
        if (rd) begin
            case (regSel)
                `REG_PORT_B_DATA: d.rdData = inRegB; // R4
                `REG_PORT_A_DATA, `REG_PORT_A_QUIET: d.rdData = inRegA; // R4
                `REG_PORT_B_DIR: d.rdData = q.dirB;
                `REG_PORT_A_DIR: d.rdData = q.dirA;
                `REG_AUX_CTRL: d.rdData = q.aux;
                `REG_PERIPH_CTRL: d.rdData = q.pctl;
                `REG_FLAGS: d.rdData = q.flags;
                default: d.rdData = `RESET_BYTE;
            endcase
        end

        // Port B capture on each input-line active edge
        if (edgeBIn) begin
            d.latchB = port_b_pins_in; // R10
        end

        // Handshaking access on port A clears its flags first
        if (accA) begin
            d.flags[`FLAG_A_IN_BIT] = 1'b0;
            d.flags[`FLAG_A_IO_BIT] = 1'b0;
        end
        if (wr && regSel == `REG_PORT_B_DATA) begin
            d.flags[`FLAG_B_IN_BIT] = 1'b0;
            d.flags[`FLAG_B_IO_BIT] = 1'b0;
        end

        // Edge sets take precedence over any clear
        if (edgeAIn) begin
            d.flags[`FLAG_A_IN_BIT] = 1'b1; // R14
        end
        if (edgeAIo && modeA == ports_pkg::IoInput) begin
            d.flags[`FLAG_A_IO_BIT] = 1'b1;
        end
        if (edgeBIn) begin
            d.flags[`FLAG_B_IN_BIT] = 1'b1;
        end
        if (edgeBIo && modeB == ports_pkg::IoInput) begin
            d.flags[`FLAG_B_IO_BIT] = 1'b1;
        end

        // Port A control-io: data taken on read, data ready on write
        case (modeA)
            ports_pkg::IoHandshake: begin
                if (accA) begin
                    d.ioAOut = 1'b0; // R13 R19
                end else if (edgeAIn && (captureReady || !latchA)) begin
                    // Full capture queue holds the peripheral off
                    d.ioAOut = 1'b1; // R19 R15 R16
                end
            end
            ports_pkg::IoPulse: begin
                d.ioAOut = ~accA; // R19
            end
            default: begin
                d.ioAOut = 1'b1;
            end
        endcase

        // Port B control-io: write handshaking only
        case (modeB)
            ports_pkg::IoHandshake: begin
                if (wr && regSel == `REG_PORT_B_DATA) begin
                    d.ioBOut = 1'b0; // R12
                end else if (edgeBIn) begin
                    d.ioBOut = 1'b1; // R12
                end
            end
            ports_pkg::IoPulse: begin
                d.ioBOut = ~(wr && regSel == `REG_PORT_B_DATA); // R12
            end
            default: begin
                d.ioBOut = 1'b1;
            end
        endcase
    end

    // State register; reset clears every register to zero except ioAOut and ioBOut, which load one
    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            q <= '0; // R17
            q.ioAOut <= 1'b1;
            q.ioBOut <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Pins: direction picks the driver, output register the level
    assign port_a_pins_out = q.outA; // R2
    assign port_a_pins_oe = q.dirA; // R1 R3
    assign port_b_pins_out = q.outB; // R2
    assign port_b_pins_oe = q.dirB; // R1 R3

    // Control-io drivers only in output modes
    assign port_a_ctrl_io_oe = (modeA != ports_pkg::IoInput);
    assign port_a_ctrl_io_out = ioLevel(modeA, q.ioAOut);
    assign port_b_ctrl_io_oe = (modeB != ports_pkg::IoInput);
    assign port_b_ctrl_io_out = ioLevel(modeB, q.ioBOut);

    // Bus read data
    assign dataOut = q.rdData;
    assign dataOe = q.rdValid;

endmodule

`default_nettype wire

// [tb/ports_properties.sv]
/*
 * Port-level checker for parallel_ports, bound to every instance.
 * Assumes one clock domain with rstn as its reset.
 */
`timescale 1ns/1ps
`default_nettype none

module ports_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Host register port
    input wire logic chipSel,
    input wire logic chipSelN,
    input wire logic [3:0] regSel,
    input wire logic readNotWrite,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    // Port pins and control lines
    input wire logic [7:0] port_a_pins_out,
    input wire logic [7:0] port_a_pins_oe,
    input wire logic [7:0] port_b_pins_out,
    input wire logic [7:0] port_b_pins_oe,
    input wire logic port_a_ctrl_in,
    input wire logic port_a_ctrl_io_out,
    input wire logic port_b_ctrl_io_out,
    input wire logic captureReady
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Decoded access kinds
    wire logic sel = chipSel && !chipSelN;
    wire logic rd = sel && readNotWrite;
    wire logic wr = sel && !readNotWrite;

    AST_RESET_IDLE: assert property ($rose(rstn) |-> !dataOe && (port_a_pins_oe | port_b_pins_oe) == 8'h00)
        else $error("pins or bus driven right after reset");
    AST_DIR_A: assert property (wr && regSel == 4'h3 |=> port_a_pins_oe == $past(dataIn))
        else $error("port A drive enables differ from direction write");
    AST_DIR_B: assert property (wr && regSel == 4'h2 |=> port_b_pins_oe == $past(dataIn))
        else $error("port B drive enables differ from direction write");
    AST_OUT_A: assert property (wr && (regSel == 4'h1 || regSel == 4'hf)
        |=> port_a_pins_out == $past(dataIn))
        else $error("port A output levels differ from output write");
    AST_OUT_B: assert property (wr && regSel == 4'h0 |=> port_b_pins_out == $past(dataIn))
        else $error("port B output levels differ from output write");
    AST_READ_STROBE: assert property (dataOe == $past(rd))
        else $error("bus drive not exactly one cycle after a read");
    AST_B_OUT_READ: assert property (rd && regSel == 4'h0
        |=> ((dataOut ^ $past(port_b_pins_out)) & $past(port_b_pins_oe)) == 8'h00)
        else $error("port B output bits did not read back as programmed");
    AST_UNMAPPED: assert property (rd && regSel inside {[4'h4:4'ha], 4'he} |=> dataOut == 8'h00)
        else $error("unmapped select read not zero");
    AST_QUIET_A: assert property (sel && regSel == 4'hf && port_a_ctrl_io_out
        |=> port_a_ctrl_io_out)
        else $error("quiet port A access touched the taken line");
    AST_B_READ_NO_HS: assert property (rd && regSel == 4'h0 && port_b_ctrl_io_out
        |=> port_b_ctrl_io_out)
        else $error("port B read started a handshake");
    AST_CAPTURE_EDGE: assert property ($fell(captureReady)
        |-> $past(port_a_ctrl_in, 4) != $past(port_a_ctrl_in, 3))
        else $error("capture without a recent ready edge");

    // Main scenarios reached
    cover property ($fell(captureReady));
    cover property (rd && regSel == 4'h0);
    cover property (sel && regSel == 4'hf);
endmodule

bind parallel_ports ports_checker u_chk (.sys_clk, .rstn, .chipSel, .chipSelN, .regSel,
    .readNotWrite, .dataIn, .dataOut, .dataOe, .port_a_pins_out, .port_a_pins_oe,
    .port_b_pins_out, .port_b_pins_oe, .port_a_ctrl_in, .port_a_ctrl_io_out,
    .port_b_ctrl_io_out, .captureReady);

`default_nettype wire

// [tb/periph_model.sv]
/*
 * Peripheral on port A: offers bytes with a data-ready edge, waits for
 * data taken, and models the wire levels including a heavy load.
 * Assumes the bench calls offer and sets loadMask and loadVal.
 */
`timescale 1ns/1ps
`default_nettype none

module periph_model (
    // Clock
    input wire logic clk,
    // Block side of port A
    input wire logic [7:0] pinsOut,
    input wire logic [7:0] pinsOe,
    input wire logic ioOut,
    input wire logic ioOe,
    // Wire levels
    output logic [7:0] pinsWire,
    output logic readyN,
    output logic ioWire
);
    logic [7:0] data = 8'h00;     // Peripheral byte
    logic [7:0] loadMask = 8'h00; // Bits held by a heavy load
    logic [7:0] loadVal = 8'h00;  // Level the load forces
    logic armed = 1'b1;           // Taken seen since last offer
    logic lastIo = 1'b0;          // Last driven taken level

    // Load beats the block, the block beats the peripheral
    assign pinsWire = (loadMask & loadVal) | (~loadMask & ((pinsOe & pinsOut) | (~pinsOe & data)));
    // Released line shows the inverse of its last level, never a stale copy
    assign ioWire = ioOe ? ioOut : ~lastIo;
    initial readyN = 1'b1;

    // Falling taken line arms the next offer
    always @(negedge clk) begin
        if (ioOe) lastIo <= ioOut;
        if (ioOe && !ioOut && lastIo) armed <= 1'b1;
    end

    // One byte: present, signal ready, hold, then let the data go
    task automatic offer(input logic [7:0] d);
        wait (armed);
        @(negedge clk);
        armed = 1'b0;
        data = d;
        readyN = 1'b0;
        repeat (10) @(negedge clk);
        data = ~d;
        readyN = 1'b1;
    endtask
endmodule

`default_nettype wire

// [tb/tb.sv]
/*
 * Self-checking bench for parallel_ports; some of the low four port A lines sit under a heavy load for one read.
 * Assumes rtl/ files, the checker and periph_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end

module tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic chipSel = 1'b0;
    logic chipSelN = 1'b1;
    logic readNotWrite = 1'b1;
    logic [3:0] regSel = 4'h0;
    logic [7:0] dataIn = 8'h00;
    logic [7:0] drvB = 8'h00;   // Forced port B levels
    logic bReadyN = 1'b1;       // Port B control input
    logic lastB = 1'b0;         // Last driven port B io level
    logic [7:0] dataOut, aOut, aOe, bOut, bOe, aWire;
    logic dataOe, ioAOut, ioAOe, ioAWire, readyN, ioBOut, ioBOe, captureReady;
    logic [15:0] expQ[$];       // Read notes: {mask, value}
    logic [7:0] d[9];
    logic [7:0] r, m, lm, e;
    int fails = 0;
    int checks_done = 0;

    parallel_ports DUT (.sys_clk, .rstn, .chipSel, .chipSelN, .regSel, .readNotWrite,
        .dataIn, .dataOut, .dataOe, .port_a_pins_in(aWire), .port_a_pins_out(aOut),
        .port_a_pins_oe(aOe), .port_b_pins_in(drvB), .port_b_pins_out(bOut),
        .port_b_pins_oe(bOe), .port_a_ctrl_in(readyN), .port_a_ctrl_io_in(ioAWire),
        .port_a_ctrl_io_out(ioAOut), .port_a_ctrl_io_oe(ioAOe), .port_b_ctrl_in(bReadyN),
        .port_b_ctrl_io_in(ioBOe ? ioBOut : ~lastB), .port_b_ctrl_io_out(ioBOut),
        .port_b_ctrl_io_oe(ioBOe), .captureReady);
    periph_model PM (.clk(sys_clk), .pinsOut(aOut), .pinsOe(aOe), .ioOut(ioAOut),
        .ioOe(ioAOe), .pinsWire(aWire), .readyN, .ioWire(ioAWire));

    // 250 MHz clock
    initial forever #2 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (ioBOe) lastB <= ioBOut;

    // Each driven read retires the oldest note
    always @(negedge sys_clk) if (dataOe === 1'b1) begin
        `CHK(dataOut & expQ[0][15:8], expQ[0][7:0] & expQ[0][15:8])
        void'(expQ.pop_front());
    end

    // One selected cycle, launched at a falling edge; reads leave a note
    task automatic acc(input logic [3:0] s, input logic rnw, input logic [7:0] v,
        input logic [7:0] msk);
        @(negedge sys_clk);
        if (rnw) expQ.push_back({msk, v});
        {chipSel, chipSelN, regSel, readNotWrite, dataIn} = {2'b10, s, rnw, v};
        @(negedge sys_clk);
        {chipSel, chipSelN} = 2'b01;
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Whole run is some 250 cycles; allow sixty times that
    initial begin
        repeat (15000) @(posedge sys_clk);
        fails++;
        $display("Timeout at %0t", $time);
        stop_test();
    end

    initial begin
        void'($urandom(13));
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        // Everything cleared and undriven
        `CHK({aOe, bOe, ioAOe, ioBOe}, 18'h0)
        foreach (d[i]) if (i < 4) acc(i == 0 ? 4'h2 : 4'h9 + 4'(i), 1, 8'h00, 8'hff);
        acc(4'h4, 0, 8'hff, 8'h00);
        acc(4'h4, 1, 8'h00, 8'hff);
        acc(4'he, 1, 8'h00, 8'hff);
        $display("Test reset done");
        // Outputs stored while input, driven once output
        r = 8'($urandom);
        m = 8'($urandom);
        PM.data = 8'($urandom);
        acc(4'h1, 0, r, 8'h00);
        acc(4'h0, 0, ~r, 8'h00);
        @(negedge sys_clk);
        `CHK({aOe, bOe, aWire}, {16'h0, PM.data})
        acc(4'h3, 0, m, 8'h00);
        acc(4'h2, 0, ~m, 8'h00);
        @(negedge sys_clk);
        `CHK({aOut, aOe, bOut, bOe}, {r, m, ~r, ~m})
        `CHK(aWire, (m & r) | (~m & PM.data))
        lm = m & 8'h0f;
        PM.loadMask = lm;
        PM.loadVal = ~r;
        e = (lm & ~r) | (~lm & ((m & r) | (~m & PM.data)));
        acc(4'hf, 1, e, 8'hff);
        drvB = 8'($urandom);
        acc(4'h0, 1, (~m & ~r) | (m & drvB), 8'hff);
        PM.loadMask = 8'h00;
        acc(4'h3, 0, 8'h00, 8'h00);
        acc(4'h2, 0, 8'h00, 8'h00);
        $display("Test ports done");
        // Port B latch on a falling control edge, then live again
        acc(4'hb, 0, 8'h02, 8'h00);
        bReadyN = 1'b0;
        repeat (6) @(negedge sys_clk);
        r = drvB;
        drvB = ~drvB;
        acc(4'h0, 1, r, 8'hff);
        acc(4'hb, 0, 8'h00, 8'h00);
        acc(4'h0, 1, drvB, 8'hff);
        // Port B handshakes on writes only
        acc(4'hc, 0, 8'h80, 8'h00);
        bReadyN = 1'b1;
        acc(4'h0, 1, drvB, 8'hff);
        `CHK(ioBOut, 1'b1)
        acc(4'h0, 0, 8'h00, 8'h00);
        `CHK({ioBOe, ioBOut}, 2'b10)
        bReadyN = 1'b0;
        repeat (6) @(negedge sys_clk);
        `CHK(ioBOut, 1'b1)
        $display("Test port B done");
        // Port A taken line: fixed levels, quiet access, one-cycle pulse
        acc(4'hc, 0, 8'h0c, 8'h00);
        `CHK({ioAOe, ioAOut}, 2'b10)
        acc(4'hc, 0, 8'h0e, 8'h00);
        `CHK({ioAOe, ioAOut}, 2'b11)
        acc(4'hc, 0, 8'h0a, 8'h00);
        acc(4'hf, 1, PM.data, 8'hff);
        `CHK(ioAOut, 1'b1)
        acc(4'h1, 0, 8'h00, 8'h00);
        `CHK(ioAOut, 1'b0)
        @(negedge sys_clk);
        `CHK(ioAOut, 1'b1)
        // Read handshake with latching, data released after the hold
        acc(4'hc, 0, 8'h08, 8'h00);
        acc(4'hb, 0, 8'h01, 8'h00);
        acc(4'hd, 0, 8'hff, 8'h00);
        for (int i = 0; i < 3; i++) begin
            d[i] = 8'($urandom);
            PM.offer(d[i]);
            `CHK(ioAOut, 1'b1)
            acc(4'hd, 1, 8'h02, 8'h02);
            acc(4'h1, 1, d[i], 8'hff);
            `CHK(ioAOut, 1'b0)
            acc(4'h1, 1, ~d[i], 8'hff);
        end
        $display("Test handshake done");
        // Fill the capture buffer past full, then drain it quietly
        acc(4'hc, 0, 8'h00, 8'h00);
        for (int i = 0; i < 9; i++) begin
            d[i] = 8'($urandom);
            PM.armed = 1'b1;
            PM.offer(d[i]);
        end
        `CHK(captureReady, 1'b0)
        for (int i = 0; i < 8; i++) acc(4'hf, 1, d[i], 8'hff);
        acc(4'hf, 1, ~d[8], 8'hff);
        @(negedge sys_clk);
        `CHK({captureReady, expQ.size()}, {1'b1, 32'd0})
        $display("Test buffer done");
        stop_test();
    end
endmodule

`default_nettype wire
